// ### hdl/sesu_regs.svh
`ifndef SESU_REGS_SVH
`define SESU_REGS_SVH
// event status bit positions
`define SESU_BIT_OPC 0
`define SESU_BIT_QRY 2
`define SESU_BIT_DEV 3
`define SESU_BIT_EXE 4
`define SESU_BIT_CMD 5
// flags that can ever be set: bits 5,4,3,2,0
`define SESU_USED_MASK 8'h3d
`define SESU_MASK_RESET 8'h00
`define SESU_FLAGS_RESET 8'h00
// summary position in the status byte
`define SESU_SUMMARY_POS 5
// ascii characters for the completion query and id replies
`define SESU_ASCII_ZERO 8'h30
`define SESU_ASCII_ONE 8'h31
`define SESU_ASCII_COMMA 8'h2c
`define SESU_ASCII_SLASH 8'h2f
`define SESU_ASCII_DIGIT0 8'h30
`define SESU_ID_LEN 34
`endif

// ### hdl/sesu_pkg.sv
package sesu_pkg;
  typedef enum logic [2:0] {
    SESU_CMD_NONE,
    SESU_CMD_CLEAR_STATUS,
    SESU_CMD_MASK_WRITE,
    SESU_CMD_MASK_READ,
    SESU_CMD_FLAGS_READ,
    SESU_CMD_OPC_ARM,
    SESU_CMD_OPC_QUERY,
    SESU_CMD_ID_QUERY
  } sesu_cmd_e;
  typedef struct packed {
    logic cmd_err;
    logic exe_err;
    logic dev_err;
    logic qry_err;
    logic fault_q;
  } sesu_err_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } sesu_byte_s;
endpackage

// ### hdl/sesu_flag_bit.sv
`timescale 1ns/10ps
// one sticky flag: set wins over clear
module sesu_flag_bit
  import sesu_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (clr_i)
      flag_q <= 1'b0;
  end
  assign flag_o = flag_q;
endmodule // sesu_flag_bit

// ### hdl/sesu_id_rom.sv
`timescale 1ns/10ps
`include "sesu_regs.svh"
// identification string: maker,model rating date,serial,revision
module sesu_id_rom
  import sesu_pkg::*;
#(
  parameter logic [7:0] MAKER_CHAR = 8'h41, // arbitrary value
  parameter logic [7:0] MODEL_CHAR = 8'h42, // arbitrary value
  parameter logic [23:0] RATING = 24'h312d31,
  parameter logic [15:0] CAL_MONTH = 16'h3031,
  parameter logic [15:0] CAL_DAY = 16'h3031,
  parameter logic [31:0] CAL_YEAR = 32'h32303030,
  parameter logic [47:0] SERIAL_DIGITS = 48'h303030303030,
  parameter logic [31:0] FW_REV = 32'h312e3030
)
(
  input wire logic [5:0] idx_i,
  output logic [7:0] char_o
);
  logic [8*`SESU_ID_LEN-1:0] str;
  assign str = {MAKER_CHAR, MAKER_CHAR, MAKER_CHAR, `SESU_ASCII_COMMA,
                MODEL_CHAR, MODEL_CHAR, MODEL_CHAR, 8'h20, RATING, 8'h20,
                CAL_MONTH, `SESU_ASCII_SLASH, CAL_DAY, `SESU_ASCII_SLASH, CAL_YEAR,
                `SESU_ASCII_COMMA, SERIAL_DIGITS, `SESU_ASCII_COMMA, FW_REV};
  always_comb
  begin
    char_o = 8'h00;
    if (idx_i < 6'(`SESU_ID_LEN))
      char_o = str[8*(`SESU_ID_LEN-1-idx_i) +: 8];
  end
endmodule // sesu_id_rom

// ### hdl/sesu_unit.sv
`timescale 1ns/10ps
`include "sesu_regs.svh"
// What this block does
// - command class error sets flag bit 5
// - execution class error sets flag bit 4
// - device class error sets flag bit 3
// - output fault also sets device error flag
// - query class error sets flag bit 2
// - bits 7,6,1 unused; bit 0 completion
// - flags read returns contents then clears
// - masked flags ORed into summary bit 5
// - mask one passes flag, zero blocks
// - mask query returns stored value unchanged
// - completion arm clears bit 0
// - bit 0 sets once all processors idle
// - commands keep running while completion pending
// - completion query replies ascii 0 while pending
// - completion query replies ascii 1 when done
// - completion query never stalls later commands
// - id reply is four comma fields
// - calibration date as MM/DD/YYYY
// - serial field has six digits
// - mask accepts 0..255, resets to 0
// - clear status empties flags, keeps mask
module sesu_unit
  import sesu_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire sesu_cmd_e cmd_i,
  input wire logic [7:0] cmd_data_i,
  input wire sesu_err_s err_i,
  input wire logic [2:0] proc_idle_i,
  output logic resp_valid_o,
  output logic [7:0] resp_data_o,
  output logic resp_last_o,
  output logic summary_o,
  output logic [7:0] status_byte_part_o,
  output logic err_queue_clear_o
);
  // ==========================================================
  // command decode
  logic take_clr, take_wr, take_mrd, take_frd, take_arm, take_oq, take_id;
  assign take_clr = cmd_valid_i && (cmd_i == SESU_CMD_CLEAR_STATUS);
  assign take_wr = cmd_valid_i && (cmd_i == SESU_CMD_MASK_WRITE);
  assign take_mrd = cmd_valid_i && (cmd_i == SESU_CMD_MASK_READ);
  assign take_frd = cmd_valid_i && (cmd_i == SESU_CMD_FLAGS_READ);
  assign take_arm = cmd_valid_i && (cmd_i == SESU_CMD_OPC_ARM);
  assign take_oq = cmd_valid_i && (cmd_i == SESU_CMD_OPC_QUERY);
  assign take_id = cmd_valid_i && (cmd_i == SESU_CMD_ID_QUERY);

  // ==========================================================
  // idle inputs come from other processors: synchronise
  logic [2:0] idle_s1_q, idle_s2_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      idle_s1_q <= 3'h0;
      idle_s2_q <= 3'h0;
    end
    else
    begin
      idle_s1_q <= proc_idle_i;
      idle_s2_q <= idle_s1_q;
    end
  end
  logic all_idle;
  assign all_idle = &idle_s2_q;

  // ==========================================================
  // enable mask
  logic [7:0] mask_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mask_q <= `SESU_MASK_RESET;
    else if (take_wr)
      mask_q <= cmd_data_i;
  end

  // ==========================================================
  // completion tracking; pending never stalls the decoder
  logic pending_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pending_q <= 1'b0;
    else if (take_clr)
      pending_q <= 1'b0;
    else if (take_arm)
      pending_q <= 1'b1;
    else if (pending_q && all_idle)
      pending_q <= 1'b0;
  end
  logic opc_set;
  assign opc_set = pending_q && all_idle && !take_arm && !take_clr;

  // ==========================================================
  // event flags
  wire logic [7:0] flags;
  logic [7:0] set_vec;
  logic flag_clr;
  assign flag_clr = take_frd || take_clr;
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`SESU_BIT_CMD] = err_i.cmd_err;
    set_vec[`SESU_BIT_EXE] = err_i.exe_err;
    set_vec[`SESU_BIT_DEV] = err_i.dev_err || err_i.fault_q;
    set_vec[`SESU_BIT_QRY] = err_i.qry_err;
    set_vec[`SESU_BIT_OPC] = opc_set;
    set_vec = set_vec & `SESU_USED_MASK;
  end
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_flag
      if (((`SESU_USED_MASK >> g) & 1) != 0)
      begin : g_used
        logic clr_b;
        // arm forces bit 0 low unless it is being set
        assign clr_b = flag_clr || ((g == `SESU_BIT_OPC) && take_arm);
        sesu_flag_bit u_bit (
          .clk_i(clk_i),
          .resetn_i(resetn_i),
          .set_i(set_vec[g]),
          .clr_i(clr_b),
          .flag_o(flags[g])
        );
      end
      else
      begin : g_unused
        assign flags[g] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // summary into the status byte
  logic summary_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      summary_q <= 1'b0;
    else
      summary_q <= |(flags & mask_q);
  end
  assign summary_o = summary_q;
  logic [7:0] sbp_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sbp_q <= 8'h00;
    else
      sbp_q <= 8'(|(flags & mask_q)) << `SESU_SUMMARY_POS;
  end
  assign status_byte_part_o = sbp_q;

  logic eqc_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      eqc_q <= 1'b0;
    else
      eqc_q <= take_clr;
  end
  assign err_queue_clear_o = eqc_q;

  // ==========================================================
  // replies; an id stream is dropped if a new query arrives
  logic id_busy_q;
  logic [5:0] id_idx_q;
  logic [7:0] id_char;
  sesu_id_rom u_rom (
    .idx_i(id_idx_q),
    .char_o(id_char)
  );
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      id_busy_q <= 1'b0;
      id_idx_q <= 6'h00;
    end
    else if (take_id)
    begin
      id_busy_q <= 1'b1;
      id_idx_q <= 6'h00;
    end
    else if (id_busy_q && !(take_mrd || take_frd || take_oq))
    begin
      id_idx_q <= id_idx_q + 6'h01;
      if (id_idx_q == 6'(`SESU_ID_LEN - 1))
        id_busy_q <= 1'b0;
    end
    else if (id_busy_q)
      id_busy_q <= 1'b0;
  end

  sesu_byte_s resp_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      resp_q <= '0;
    else if (take_mrd)
      resp_q <= '{valid: 1'b1, data: mask_q, last: 1'b1};
    else if (take_frd)
      resp_q <= '{valid: 1'b1, data: flags, last: 1'b1};
    else if (take_oq)
      resp_q <= '{valid: 1'b1, data: pending_q ? `SESU_ASCII_ZERO : `SESU_ASCII_ONE,
                  last: 1'b1};
    else if (id_busy_q)
      resp_q <= '{valid: 1'b1, data: id_char,
                  last: id_idx_q == 6'(`SESU_ID_LEN - 1)};
    else
      resp_q <= '0;
  end
  assign resp_valid_o = resp_q.valid;
  assign resp_data_o = resp_q.data;
  assign resp_last_o = resp_q.last;

  // ==========================================================
  // shadow of the last mask write, kept apart from mask_q
  // so the readback check does not lean on the register it checks
  logic [7:0] mask_shadow_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mask_shadow_q <= `SESU_MASK_RESET;
    else if (take_wr)
      mask_shadow_q <= cmd_data_i;
  end

  // ==========================================================
  // checks
  sequence arm_s;
    take_arm && !take_clr;
  endsequence
  sequence done_s;
    pending_q && all_idle && !take_arm && !take_clr;
  endsequence
  flags_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_frd && !(|set_vec) |=> flags == 8'h00)
    else $error("flags not cleared after read");
  flags_readout_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_frd |=> resp_valid_o && resp_data_o == $past(flags))
    else $error("flags read wrong");
  cmd_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    err_i.cmd_err |=> flags[5])
    else $error("command error not flagged");
  exe_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    err_i.exe_err |=> flags[4])
    else $error("execution error not flagged");
  dev_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    err_i.fault_q || err_i.dev_err |=> flags[3])
    else $error("device error not flagged");
  qry_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    err_i.qry_err |=> flags[2])
    else $error("query error not flagged");
  unused_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flags & ~`SESU_USED_MASK) == 8'h00)
    else $error("unused flag set");
  arm_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    arm_s |=> !flags[0] && pending_q)
    else $error("arm did not clear bit 0");
  opc_done_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done_s |=> flags[0] && !pending_q)
    else $error("completion not flagged");
  opc_reply_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_oq |=> resp_data_o == ($past(pending_q) ? 8'h30 : 8'h31))
    else $error("completion reply wrong");
  mask_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_clr && !take_wr |=> mask_q == $past(mask_q))
    else $error("clear status touched mask");
  summary_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ##1 summary_o == |($past(flags) & $past(mask_q)))
    else $error("summary wrong");
  mask_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_mrd |=> resp_data_o == $past(mask_shadow_q))
    else $error("mask readback wrong");
  // clear status steps: flags, pending and the queue pulse
  sequence clear_s;
    take_clr;
  endsequence
  sequence clear_quiet_s;
    take_clr && !(|set_vec);
  endsequence
  clr_flags_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clear_quiet_s |=> flags == 8'h00)
    else $error("clear status left flags");
  clr_pending_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clear_s |=> !pending_q)
    else $error("clear status left pending");
  eq_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clear_s |=> err_queue_clear_o)
    else $error("error queue clear missing");
  eq_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !take_clr |=> !err_queue_clear_o)
    else $error("stray error queue clear");
  mask_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_wr |=> mask_q == $past(cmd_data_i))
    else $error("mask write not stored");
  mask_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !take_wr |=> $stable(mask_q))
    else $error("mask changed without write");
  set_wins_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_frd && (|set_vec) |=> (flags & $past(set_vec)) == $past(set_vec))
    else $error("event lost at read");
  flag_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !flag_clr && !take_arm |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without clear");
  resp_single_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_frd |=> resp_last_o)
    else $error("flags reply not last");
  summary_block_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flags & mask_q) == 8'h00 |=> !summary_o)
    else $error("masked flag reached summary");
  sbp_form_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_byte_part_o == {2'b00, summary_o, 5'h00})
    else $error("status byte part wrong");
  opc_answer_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_oq |=> resp_valid_o && resp_last_o)
    else $error("completion query stalled");
  opc_ready_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_oq && !pending_q |=> resp_data_o == 8'h31)
    else $error("completion done reply wrong");
  busy_serve_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pending_q && take_mrd |=> resp_valid_o && resp_data_o == $past(mask_q))
    else $error("command stalled while pending");
  opc_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pending_q |-> !flags[0])
    else $error("bit 0 set while pending");
  id_first_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_id |-> ##2 resp_valid_o)
    else $error("id reply did not start");
  id_last_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    id_busy_q && id_idx_q == 6'(`SESU_ID_LEN - 1) && !(take_mrd || take_frd || take_oq || take_id)
    |=> resp_last_o && !id_busy_q)
    else $error("id reply end wrong");
  id_abort_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    id_busy_q && (take_mrd || take_frd || take_oq) |=> !id_busy_q)
    else $error("id stream not dropped");
endmodule // sesu_unit

// ### tb/sesu_ctrl_model.sv
`timescale 1ns/10ps
// ==========================================
// remote controller: one command per call
module sesu_ctrl_model
  import sesu_pkg::*;
(
  input wire logic clk_i,
  output logic cmd_valid_o,
  output sesu_cmd_e cmd_o,
  output logic [7:0] cmd_data_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o = SESU_CMD_NONE;
    cmd_data_o = 8'h00;
  end
  // launched after an edge, held until the taking edge
  task automatic issue(input sesu_cmd_e c, input logic [7:0] d);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= c;
    cmd_data_o <= d;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= SESU_CMD_NONE;
    // stale data is inverted so a late sample cannot pass by luck
    cmd_data_o <= ~d;
  endtask
endmodule // sesu_ctrl_model

// ### tb/sesu_unit_test.sv
`timescale 1ns/10ps
`include "sesu_regs.svh"
module sesu_unit_test;
  import sesu_pkg::*;
  logic clk;
  logic resetn;
  logic cmd_valid;
  sesu_cmd_e cmd;
  logic [7:0] cmd_data;
  sesu_err_s err;
  logic [2:0] idle;
  logic resp_valid;
  logic resp_last;
  logic summary;
  logic eq_clr;
  logic [7:0] resp_data;
  logic [7:0] sb;
  logic [7:0] rd;
  logic [7:0] fm;
  logic [7:0] mm;
  int failures;
  int checked;
  int n;
  int commas;
  int slashes;
  int serial;
  // ==========================================
  // design and controller
  sesu_unit i_sesu_unit (.clk_i(clk), .resetn_i(resetn), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd), .cmd_data_i(cmd_data), .err_i(err), .proc_idle_i(idle),
    .resp_valid_o(resp_valid), .resp_data_o(resp_data), .resp_last_o(resp_last),
    .summary_o(summary), .status_byte_part_o(sb), .err_queue_clear_o(eq_clr));
  sesu_ctrl_model i_ctrl (.clk_i(clk), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .cmd_data_o(cmd_data));
  // ==========================================
  // tasks
  task automatic results();
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic get(output logic [7:0] d);
    for (int i = 0; i < 4; i++)
    begin
      #1;
      if (resp_valid === 1'b1)
      begin
        d = resp_data;
        return;
      end
      @(posedge clk);
    end
    failures++;
    results();
  endtask
  task automatic ask(input sesu_cmd_e c, input logic [7:0] exp);
    i_ctrl.issue(c, 8'h00);
    get(rd);
    chk(rd, exp);
    chk({7'h00, resp_last}, 8'h01);
  endtask
  // error pulse; the model keeps only the four error flag positions, bits 5 to 2
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    err <= sesu_err_s'(e);
    @(posedge clk);
    err <= '0;
    repeat (3) @(posedge clk);
    fm = fm | {2'b00, e[4], e[3], e[2] | e[0], e[1], 2'b00};
  endtask
  task automatic summ();
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, summary}, {7'h00, |(fm & mm)});
    chk(sb, {2'b00, |(fm & mm), 5'h00});
  endtask
  // ==========================================
  // sequence
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    failures = 0;
    checked = 0;
    resetn = 1'b0;
    err = '0;
    idle = 3'b111;
    fm = 8'h00;
    mm = 8'h00;
    void'($urandom(32'hf0a85ab2));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    ask(SESU_CMD_MASK_READ, 8'h00);
    ask(SESU_CMD_FLAGS_READ, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      pulse(5'h01 << k);
      ask(SESU_CMD_FLAGS_READ, fm);
      fm = 8'h00;
    end
    for (int k = 0; k < 12; k++)
    begin
      mm = 8'($urandom);
      i_ctrl.issue(SESU_CMD_MASK_WRITE, mm);
      pulse(5'($urandom));
      summ();
      ask(SESU_CMD_MASK_READ, mm);
      ask(SESU_CMD_FLAGS_READ, fm);
      fm = 8'h00;
      summ();
    end
    pulse(5'h10);
    fork
      i_ctrl.issue(SESU_CMD_FLAGS_READ, 8'h00);
      begin
        @(posedge clk);
        err <= sesu_err_s'(5'h08);
        @(posedge clk);
        err <= '0;
      end
    join
    get(rd);
    chk(rd, 8'h20);
    ask(SESU_CMD_FLAGS_READ, 8'h10);
    fm = 8'h00;
    pulse(5'h1f);
    i_ctrl.issue(SESU_CMD_MASK_WRITE, 8'h3c);
    mm = 8'h3c;
    i_ctrl.issue(SESU_CMD_CLEAR_STATUS, 8'h00);
    n = 0;
    repeat (3)
    begin
      #1;
      n += (eq_clr === 1'b1);
      @(posedge clk);
    end
    chk(8'(n), 8'h01);
    fm = 8'h00;
    summ();
    ask(SESU_CMD_MASK_READ, 8'h3c);
    ask(SESU_CMD_FLAGS_READ, 8'h00);
    // idle must be low through the synchroniser before arming
    @(posedge clk);
    idle <= 3'b000;
    repeat (4) @(posedge clk);
    i_ctrl.issue(SESU_CMD_OPC_ARM, 8'h00);
    ask(SESU_CMD_OPC_QUERY, `SESU_ASCII_ZERO);
    ask(SESU_CMD_MASK_READ, 8'h3c);
    @(posedge clk);
    idle <= 3'b011;
    repeat (5) @(posedge clk);
    ask(SESU_CMD_OPC_QUERY, `SESU_ASCII_ZERO);
    ask(SESU_CMD_FLAGS_READ, 8'h00);
    @(posedge clk);
    idle <= 3'b111;
    repeat (5) @(posedge clk);
    ask(SESU_CMD_OPC_QUERY, `SESU_ASCII_ONE);
    fm = 8'h01;
    summ();
    ask(SESU_CMD_FLAGS_READ, 8'h01);
    i_ctrl.issue(SESU_CMD_ID_QUERY, 8'h00);
    n = 0;
    commas = 0;
    slashes = 0;
    serial = 0;
    for (int i = 0; i < 40; i++)
    begin
      #1;
      if (resp_valid === 1'b1)
      begin
        n++;
        commas += (resp_data === `SESU_ASCII_COMMA);
        slashes += (resp_data === `SESU_ASCII_SLASH);
        if (commas == 2 && resp_data >= 8'h30 && resp_data <= 8'h39)
          serial++;
        if (resp_last === 1'b1)
          break;
      end
      @(posedge clk);
    end
    chk(8'(n), 8'(`SESU_ID_LEN));
    chk(8'(commas), 8'h03);
    chk(8'(slashes), 8'h02);
    chk(8'(serial), 8'h06);
    // a query in mid stream is answered and the stream stops
    i_ctrl.issue(SESU_CMD_ID_QUERY, 8'h00);
    repeat (3) @(posedge clk);
    ask(SESU_CMD_MASK_READ, 8'h3c);
    n = 0;
    repeat (3)
    begin
      @(posedge clk);
      #1;
      n += (resp_valid === 1'b1);
    end
    chk(8'(n), 8'h00);
    results();
  end
endmodule // sesu_unit_test
